//--- shared/pmtw_pkg.sv
// Package for the oscillator trim, wake-up and PLL limit register block
// What this block does
// - Protection blocks writes to protected registers
// - Protection bit changes only with right key
// - Low range trim: user field or factory
// - Mid range trim: user field or factory
// - High range trim: user field or factory
// - Enable register sets wake bits, zero ignored
// - Disable register clears wake bits, zero ignored
// - Status shows enabled; peripheral may clear it
// - Only eligible peripherals may enable wake
// - Activity bits show eligible peripheral activity
// - Ineligible activity bits read zero
// - First multiplier saturates at first limit
// - First limit write cancelled on conflict
// - Second multiplier saturates at second limit
// - Second limit write cancelled on conflict
package pmtw_pkg;
   localparam int MW = 11;
   localparam int TW = 7;
   localparam logic [31:0] OFS_PROTECT = 32'h400E_04E4;
   localparam logic [31:0] OFS_TRIM = 32'h400E_0510;
   localparam logic [31:0] OFS_WAKE_SET = 32'h400E_0514;
   localparam logic [31:0] OFS_WAKE_CLR = 32'h400E_0518;
   localparam logic [31:0] OFS_WAKE_STATE = 32'h400E_051C;
   localparam logic [31:0] OFS_ACTIVITY = 32'h400E_0520;
   localparam logic [31:0] OFS_PLL_LIMIT = 32'h400E_0530;
   localparam logic [23:0] PROTECT_KEY = 24'h504D43;
   localparam int KEY_LSB = 8;
   localparam int LOW_LSB = 0;
   localparam int MID_LSB = 8;
   localparam int HIGH_LSB = 16;
   localparam int SEL_OFS = 7;
   localparam int LIM_A_LSB = 0;
   localparam int LIM_B_LSB = 16;
   localparam logic [31:0] WAKE_FIELD = 32'h3FFF_FF00;
   localparam logic [31:0] ELIGIBLE_RST = 32'h2000_FF00;
   localparam logic [23:0] TRIM_RST = 24'h00_0000;
   localparam logic [MW-1:0] LIMIT_RST = 11'h7FF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic wp;
      logic [23:0] trim;
      logic [31:0] wake;
      logic [MW-1:0] lim_a;
      logic [MW-1:0] lim_b;
      logic wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
      logic [TW-1:0] trim_low;
      logic [TW-1:0] trim_mid;
      logic [TW-1:0] trim_high;
      logic [MW-1:0] mul_a;
      logic [MW-1:0] mul_b;
      logic [31:0] wake_out;
      logic ready;
      logic resp;
   } pmtw_state_t;
endpackage

//--- rtl/pmtw_top.sv
// Trim selection, partial wake-up and PLL multiplier limits over AHB-Lite
//
// Implementation choice: the AHB-Lite register port.
module pmtw_top
   import pmtw_pkg::*;
#(
   parameter logic [31:0] ELIGIBLE = pmtw_pkg::ELIGIBLE_RST
)
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [pmtw_pkg::TW-1:0] factory_low_i,
   input wire logic [pmtw_pkg::TW-1:0] factory_mid_i,
   input wire logic [pmtw_pkg::TW-1:0] factory_high_i,
   output logic [pmtw_pkg::TW-1:0] trim_low_o,
   output logic [pmtw_pkg::TW-1:0] trim_mid_o,
   output logic [pmtw_pkg::TW-1:0] trim_high_o,
   input wire logic [31:0] wake_clear_i,
   input wire logic [31:0] periph_active_i,
   output logic [31:0] wake_enable_o,
   input wire logic [pmtw_pkg::MW-1:0] first_pll_multiplier_i,
   input wire logic [pmtw_pkg::MW-1:0] second_pll_multiplier_i,
   output logic [pmtw_pkg::MW-1:0] first_pll_mult_o,
   output logic [pmtw_pkg::MW-1:0] second_pll_mult_o
);
   import pmtw_pkg::*;

   localparam pmtw_state_t ST_RST = '{
      wp: 1'b0,
      trim: TRIM_RST,
      wake: 32'h0000_0000,
      lim_a: LIMIT_RST,
      lim_b: LIMIT_RST,
      wr_pend: 1'b0,
      wr_addr: 32'h0000_0000,
      rdata: 32'h0000_0000,
      trim_low: 7'h00,
      trim_mid: 7'h00,
      trim_high: 7'h00,
      mul_a: 11'h000,
      mul_b: 11'h000,
      wake_out: 32'h0000_0000,
      ready: 1'b1,
      resp: 1'b0
   };

   localparam logic [31:0] WAKE_OK = ELIGIBLE & WAKE_FIELD;

   pmtw_state_t s_q;
   pmtw_state_t s_d;
   logic addr_phase;
   logic wr_ok;
   logic [31:0] wd;
   localparam int RANGE_LSB [3] = '{LOW_LSB, MID_LSB, HIGH_LSB};

   logic [31:0] set_bits;
   logic [31:0] clr_bits;
   logic hit_set;
   logic hit_clr;
   logic [31:0] wake_next;
   logic [TW-1:0] trim_factory [3];
   logic [TW-1:0] trim_user [3];
   logic trim_sel [3];
   logic [TW-1:0] trim_pick [3];
   logic [MW-1:0] mult_req [2];
   logic [MW-1:0] lim_cur [2];
   logic [MW-1:0] lim_new [2];
   logic sat_now [2];
   logic lim_take [2];
   logic [MW-1:0] mult_cap [2];

   assign addr_phase = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

   // Data-phase write decode
   assign wr_ok = s_q.wr_pend && !s_q.wp;
   assign hit_set = wr_ok && (s_q.wr_addr == OFS_WAKE_SET);
   assign hit_clr = wr_ok && (s_q.wr_addr == OFS_WAKE_CLR);
   assign set_bits = hit_set ? (hwdata_i & WAKE_OK) : 32'h0000_0000;
   assign clr_bits = wake_clear_i | (hit_clr ? (hwdata_i & WAKE_FIELD) : 32'h0000_0000);

   // Per-bit wake state, set beats clear
   for (genvar b = 0; b < 32; b++)
   begin : g_wake
      assign wake_next[b] = WAKE_OK[b] && (set_bits[b] || (s_q.wake[b] && !clr_bits[b]));
   end

   assign trim_factory[0] = factory_low_i;
   assign trim_factory[1] = factory_mid_i;
   assign trim_factory[2] = factory_high_i;

   // Select bit picks the user field over the factory value
   for (genvar g = 0; g < 3; g++)
   begin : g_trim
      assign trim_user[g] = s_q.trim[RANGE_LSB[g] +: TW];
      assign trim_sel[g] = s_q.trim[RANGE_LSB[g] + SEL_OFS];
      assign trim_pick[g] = trim_sel[g] ? trim_user[g] : trim_factory[g];
   end

   assign mult_req[0] = first_pll_multiplier_i;
   assign mult_req[1] = second_pll_multiplier_i;
   assign lim_cur[0] = s_q.lim_a;
   assign lim_cur[1] = s_q.lim_b;
   assign lim_new[0] = hwdata_i[LIM_A_LSB +: MW];
   assign lim_new[1] = hwdata_i[LIM_B_LSB +: MW];

   // Limit write needs no saturation now and a new limit at or above the multiplier
   for (genvar p = 0; p < 2; p++)
   begin : g_pll
      assign sat_now[p] = mult_req[p] > lim_cur[p];
      assign mult_cap[p] = sat_now[p] ? lim_cur[p] : mult_req[p];
      assign lim_take[p] = !sat_now[p] && (lim_new[p] >= mult_req[p]);
   end

   always_comb
   begin
      s_d = s_q;
      wd = hwdata_i;
      s_d.wr_pend = 1'b0;
      if (s_q.wr_pend && s_q.wr_addr == OFS_PROTECT)
      begin
         if (wd[KEY_LSB +: 24] == PROTECT_KEY)
         begin
            s_d.wp = wd[0];
         end
      end
      if (wr_ok)
      begin
         case (s_q.wr_addr)
            OFS_TRIM:
            begin
               s_d.trim = wd[23:0];
            end
            OFS_PLL_LIMIT:
            begin
               if (lim_take[0])
               begin
                  s_d.lim_a = lim_new[0];
               end
               if (lim_take[1])
               begin
                  s_d.lim_b = lim_new[1];
               end
            end
            default:
            begin
               s_d.trim = s_q.trim;
            end
         endcase
      end
      s_d.wake = wake_next;
      if (addr_phase)
      begin
         s_d.wr_pend = hwrite_i;
         s_d.wr_addr = haddr_i;
      end
      s_d.rdata = 32'h0000_0000;
      // Next-state values, so a read right after a write sees it
      if (addr_phase && !hwrite_i)
      begin
         case (haddr_i)
            OFS_PROTECT:
            begin
               s_d.rdata = {31'h0000_0000, s_d.wp};
            end
            OFS_TRIM:
            begin
               s_d.rdata = {8'h00, s_d.trim};
            end
            OFS_WAKE_STATE:
            begin
               s_d.rdata = s_d.wake;
            end
            OFS_ACTIVITY:
            begin
               s_d.rdata = periph_active_i & WAKE_OK;
            end
            OFS_PLL_LIMIT:
            begin
               s_d.rdata = {5'h00, s_d.lim_b, 5'h00, s_d.lim_a};
            end
            default:
            begin
               s_d.rdata = 32'h0000_0000;
            end
         endcase
      end
      s_d.trim_low = trim_pick[0];
      s_d.trim_mid = trim_pick[1];
      s_d.trim_high = trim_pick[2];
      s_d.mul_a = mult_cap[0];
      s_d.mul_b = mult_cap[1];
      s_d.wake_out = s_q.wake;
      s_d.ready = 1'b1;
      s_d.resp = 1'b0;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         s_q <= ST_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign hrdata_o = s_q.rdata;
   assign hreadyout_o = s_q.ready;
   assign hresp_o = s_q.resp;
   assign trim_low_o = s_q.trim_low;
   assign trim_mid_o = s_q.trim_mid;
   assign trim_high_o = s_q.trim_high;
   assign wake_enable_o = s_q.wake_out;
   assign first_pll_mult_o = s_q.mul_a;
   assign second_pll_mult_o = s_q.mul_b;
endmodule

//--- tb/pmtw_asserts.sv
// Port checks for the trim, wake-up and PLL limit block
module pmtw_asserts
   import pmtw_pkg::*;
#(
   parameter logic [31:0] ELIGIBLE = ELIGIBLE_RST
)
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] periph_active_i,
   input wire logic [31:0] wake_enable_o,
   input wire logic [MW-1:0] first_pll_multiplier_i,
   input wire logic [MW-1:0] second_pll_multiplier_i,
   input wire logic [MW-1:0] first_pll_mult_o,
   input wire logic [MW-1:0] second_pll_mult_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rd(a);
      hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i && haddr_i == a;
   endsequence
   a_ready_okay: assert property (hreadyout_o && !hresp_o) else $error("bus wait or error");
   a_idle_zero: assert property (!(hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i)
      |=> hrdata_o == 32'h0) else $error("read data outside read");
   a_mult_a_cap: assert property (first_pll_mult_o <= $past(first_pll_multiplier_i))
      else $error("first multiplier raised");
   a_mult_b_cap: assert property (second_pll_mult_o <= $past(second_pll_multiplier_i))
      else $error("second multiplier raised");
   a_wake_elig: assert property ((wake_enable_o & ~ELIGIBLE) == 32'h0) else $error("wake on ineligible");
   a_act_read: assert property (s_rd(OFS_ACTIVITY) |=>
      hrdata_o == ($past(periph_active_i) & ELIGIBLE & WAKE_FIELD)) else $error("activity read wrong");
   a_state_field: assert property (s_rd(OFS_WAKE_STATE) |=> (hrdata_o & ~ELIGIBLE) == 32'h0)
      else $error("wake state ineligible bit");
   a_key_hidden: assert property (s_rd(OFS_PROTECT) |=> hrdata_o[31:1] == 31'h0)
      else $error("key field read nonzero");
endmodule
bind pmtw_top pmtw_asserts #(.ELIGIBLE(ELIGIBLE)) u_chk (.*);

//--- tb/testbench.sv
// Register-level bench for the trim, wake-up and PLL limit block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pmtw_pkg::*;
   logic clk = 0, rst = 1, hsel = 0, hwr = 0;
   logic [1:0] htr = 0;
   logic [31:0] ha = 0, hwd = 0, hrd, wclr = 0, act = 0, wen, r;
   logic rdy, resp;
   logic [6:0] fl = 7'h15, fm = 7'h2A, fh = 7'h33, tl, tm, th;
   logic [10:0] ma = 11'h064, mb = 11'h032, oa, ob;
   int failures = 0, samples_checked = 0, cyc = 0;
   pmtw_top DUT (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(ha), .htrans_i(htr), .hwrite_i(hwr),
      .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy), .hresp_o(resp),
      .factory_low_i(fl), .factory_mid_i(fm), .factory_high_i(fh), .trim_low_o(tl), .trim_mid_o(tm),
      .trim_high_o(th), .wake_clear_i(wclr), .periph_active_i(act), .wake_enable_o(wen),
      .first_pll_multiplier_i(ma), .second_pll_multiplier_i(mb), .first_pll_mult_o(oa), .second_pll_mult_o(ob));
   always #50 clk = ~clk;
   task conclude();
      if (failures == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         conclude();
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // One AHB-Lite single transfer
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1;
      ha <= a;
      htr <= HTRANS_NONSEQ;
      hwr <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      hsel <= 0;
      htr <= 2'h0;
      hwd <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      r = hrd;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
      repeat (3) @(posedge clk);
   endtask
   task rd(input string n, input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(n, e, r);
      chk("resp", 32'h0, {31'h0, resp});
   endtask
   task outs(input logic [31:0] e);
      chk("trims", e, {11'h0, th, tm, tl});
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd("trim", OFS_TRIM, TRIM_RST);
      rd("limit", OFS_PLL_LIMIT, 32'h07FF_07FF);
      outs({11'h0, fh, fm, fl});
      wr(OFS_TRIM, 32'h00D5_459B);
      outs({11'h0, 7'h55, fm, 7'h1B});
      wr(OFS_TRIM, 32'h0080_C000);
      outs({11'h0, 7'h00, 7'h40, fl});
      rd("trim", OFS_TRIM, 32'h0080_C000);
      wr(OFS_WAKE_SET, 32'hFFFF_FFFF);
      wr(OFS_WAKE_SET, 32'h0);
      rd("state", OFS_WAKE_STATE, ELIGIBLE_RST);
      wr(OFS_WAKE_CLR, 32'h0000_0F00);
      wr(OFS_WAKE_CLR, 32'h0);
      chk("wake", 32'h2000_F000, wen);
      wclr <= 32'h0000_1000;
      @(posedge clk);
      wclr <= 32'h0;
      rd("state", OFS_WAKE_STATE, 32'h2000_E000);
      act <= 32'hFFFF_FFFF;
      @(posedge clk);
      rd("activity", OFS_ACTIVITY, ELIGIBLE_RST);
      chk("mults", {11'h032, 11'h064}, {ob, oa});
      wr(OFS_PLL_LIMIT, 32'h0028_00C8);
      rd("limit", OFS_PLL_LIMIT, 32'h07FF_00C8);
      ma <= 11'h12C;
      wr(OFS_PLL_LIMIT, 32'h003C_0190);
      rd("limit", OFS_PLL_LIMIT, 32'h003C_00C8);
      mb <= 11'h046;
      repeat (3) @(posedge clk);
      chk("mults", {11'h03C, 11'h0C8}, {ob, oa});
      ma <= 11'h064;
      mb <= 11'h032;
      wr(OFS_PROTECT, 32'h1234_5601);
      rd("protect", OFS_PROTECT, 32'h0);
      wr(OFS_PROTECT, 32'h504D_4301);
      rd("protect", OFS_PROTECT, 32'h1);
      wr(OFS_TRIM, 32'h0);
      wr(OFS_WAKE_CLR, 32'hFFFF_FFFF);
      wr(OFS_PLL_LIMIT, 32'h07FF_07FF);
      rd("trim", OFS_TRIM, 32'h0080_C000);
      rd("state", OFS_WAKE_STATE, 32'h2000_E000);
      rd("limit", OFS_PLL_LIMIT, 32'h003C_00C8);
      rd("unmapped", 32'h400E_0540, 32'h0);
      wr(OFS_PROTECT, 32'h504D_4300);
      wr(OFS_WAKE_CLR, 32'hFFFF_FFFF);
      chk("wake", 32'h0, wen);
      conclude();
   end
endmodule
